// ---- pkg/tlia_pkg.sv ----
// Purpose: constants for the top level interrupt aggregator
// Assumes: 32-bit register port, word offsets as byte addresses
// Notes:   none
//
// What this block does
// RULE1 - status bits follow sources whatever the enable, bar software irq
// RULE2 - writing 1 to a latched status bit clears it; 0 leaves it
// RULE3 - bit 31 sets when software sets its enable; write one clears
// RULE4 - bit 30 latches when device becomes ready; write one clears
// RULE5 - bit 29 read-only mirror of the time unit event output
// RULE6 - bit 28 read-only mirror of switch fabric pending interrupt
// RULE7 - bit 27 read-only mirror of port b transceiver interrupt
// RULE8 - bit 26 read-only mirror of port a transceiver interrupt
// RULE9 - bit 19 latches when timer count wraps zero to FFFFh; one clears
// RULE10 - bit 12 read-only mirror of the gpio pending interrupt
// RULE11 - enable bit 1 admits matching status bit to the request output
// RULE12 - enable uses same bit positions; others reserved read-only
// RULE13 - latched status bits and all enable bits reset to zero; mirror bits follow their sources
// RULE14 - output-enable clear holds request output low; status still updates
// RULE15 - master status bit shows 1 when any enabled interrupt active
// RULE16 - internal line is OR of status AND enable, every cycle
// RULE17 - writes to read-only and reserved bits ignored; reserved read zero
package tlia_pkg;
    localparam logic [11:0] STATUS_OFFSET = 12'h058;
    localparam logic [11:0] ENABLE_OFFSET = 12'h05C;
    localparam logic [11:0] CONTROL_OFFSET = 12'h060;
    localparam int SW_BIT    = 31;
    localparam int READY_BIT = 30;
    localparam int PTP_BIT   = 29;
    localparam int FABRIC_BIT = 28;
    localparam int PORTB_BIT = 27;
    localparam int PORTA_BIT = 26;
    localparam int TIMER_BIT = 19;
    localparam int GPIO_BIT  = 12;
    localparam int MASTER_BIT = 12;
    localparam int OUTEN_BIT = 8;
    localparam logic [31:0] IMPL_MASK  = 32'hFC081000;
    localparam logic [31:0] LATCH_MASK = 32'hC0080000;
    localparam logic [31:0] RESET_VALUE = 32'h00000000;
    localparam logic [15:0] TIMER_WRAP = 16'hFFFF;
    localparam logic [15:0] TIMER_ZERO = 16'h0000;
endpackage : tlia_pkg

// ---- hw/tlia_edge_latch.sv ----
// Purpose: sticky event flag with write-one-to-clear
// Assumes: set and clear are single-cycle strobes
// Notes:   set wins over a clear in the same cycle
`timescale 1ns/1ps
`default_nettype none
module tlia_edge_latch (
    input  wire logic sys_clk,
    input  wire logic nrst,
    input  wire logic setEvent,
    input  wire logic clearEvent,
    output var  logic flag
);
    import tlia_pkg::*;
    logic next_flag;
    // set beats clear so no event is lost
    assign next_flag = setEvent | (flag & ~clearEvent); // [RULE2]
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
            flag <= RESET_VALUE[0]; // [RULE13]
        else
            flag <= next_flag;
    end
endmodule : tlia_edge_latch
`default_nettype wire

// ---- hw/tlia_timer_wrap.sv ----
// Purpose: detect timer count wrapping from zero to FFFFh
// Assumes: count sampled each clock
// Notes:   one-cycle pulse on wrap
`timescale 1ns/1ps
`default_nettype none
module tlia_timer_wrap (
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic [15:0] timerCount,
    output var  logic        wrapPulse
);
    import tlia_pkg::*;
    logic        sawZero;
    logic        isWrap;
    assign isWrap = sawZero & (timerCount == TIMER_WRAP); // [RULE9]
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            sawZero   <= 1'h0;
            wrapPulse <= 1'h0;
        end
        else
        begin
            sawZero   <= (timerCount == TIMER_ZERO);
            wrapPulse <= isWrap;
        end
    end
endmodule : tlia_timer_wrap
`default_nettype wire

// ---- hw/top_level_interrupt_aggregator.sv ----
// Purpose: gathers event flags into status, gates by enable, drives irq
// Assumes: register port writes and reads are single-cycle strobes
// Notes:   read data is registered, valid the cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module top_level_interrupt_aggregator (
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic [11:0] regAddr,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    input  wire logic [31:0] regWdata,
    output var  logic [31:0] regRdata,
    input  wire logic        deviceReady,
    input  wire logic        ptp_unit_event,
    input  wire logic        fabricEvent,
    input  wire logic        port_b_transceiver_event,
    input  wire logic        port_a_transceiver_event,
    input  wire logic [15:0] timer_count,
    input  wire logic        gpioEvent,
    output var  logic        irqOut,
    output var  logic        masterIrq
);
    import tlia_pkg::*;

    logic [31:0] interrupt_enable;
    logic        outputEnable;
    logic        software_irq_flag;
    logic        readyFlag;
    logic        timer_wrap_flag;
    logic        timerWrap;
    logic        readyPrev;
    logic        swEnPrev;
    logic        irqLine;
    logic        next_irqOut;

    wire         hitStatus  = (regAddr == STATUS_OFFSET);
    wire         hitEnable  = (regAddr == ENABLE_OFFSET);
    wire         hitControl = (regAddr == CONTROL_OFFSET);
    wire         wrStatus   = regWrite & hitStatus;
    wire         wrEnable   = regWrite & hitEnable;
    wire         wrControl  = regWrite & hitControl;

    wire         software_irq_trigger_enable = interrupt_enable[SW_BIT];

    // software flag fires on the rising edge of its enable
    wire         swSet    = software_irq_trigger_enable & ~swEnPrev; // [RULE3]
    wire         readySet = deviceReady & ~readyPrev;                // [RULE4]

    logic [31:0] interrupt_status;
    always_comb
    begin
        interrupt_status             = 32'h00000000; // [RULE17]
        interrupt_status[SW_BIT]     = software_irq_flag;        // [RULE3]
        interrupt_status[READY_BIT]  = readyFlag;                // [RULE4]
        interrupt_status[PTP_BIT]    = ptp_unit_event;           // [RULE5]
        interrupt_status[FABRIC_BIT] = fabricEvent;              // [RULE6]
        interrupt_status[PORTB_BIT]  = port_b_transceiver_event; // [RULE7]
        interrupt_status[PORTA_BIT]  = port_a_transceiver_event; // [RULE8]
        interrupt_status[TIMER_BIT]  = timer_wrap_flag;          // [RULE9]
        interrupt_status[GPIO_BIT]   = gpioEvent;                // [RULE10]
    end

    // status shows sources regardless of enable, bar the software bit, which sets on its enable's rising edge
    wire [31:0] gated = interrupt_status & interrupt_enable; // [RULE1] [RULE11]
    assign irqLine     = |gated;                             // [RULE16]
    assign next_irqOut = irqLine & outputEnable;             // [RULE14]

    wire [31:0] controlRead = {19'h00000, irqLine, 3'h0, outputEnable,
                               8'h00}; // [RULE15]
    wire [31:0] readMux = hitStatus  ? interrupt_status :
                          hitEnable  ? interrupt_enable :
                          hitControl ? controlRead : 32'h00000000;

    tlia_edge_latch swLatch (
        .sys_clk    (sys_clk),
        .nrst       (nrst),
        .setEvent   (swSet),
        .clearEvent (wrStatus & regWdata[SW_BIT]),
        .flag       (software_irq_flag)
    );

    tlia_edge_latch readyLatch (
        .sys_clk    (sys_clk),
        .nrst       (nrst),
        .setEvent   (readySet),
        .clearEvent (wrStatus & regWdata[READY_BIT]),
        .flag       (readyFlag)
    );

    tlia_timer_wrap wrapDetect (
        .sys_clk    (sys_clk),
        .nrst       (nrst),
        .timerCount (timer_count),
        .wrapPulse  (timerWrap)
    );

    tlia_edge_latch timerLatch (
        .sys_clk    (sys_clk),
        .nrst       (nrst),
        .setEvent   (timerWrap),
        .clearEvent (wrStatus & regWdata[TIMER_BIT]),
        .flag       (timer_wrap_flag)
    );

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            interrupt_enable <= RESET_VALUE; // [RULE13]
            outputEnable     <= 1'h0;
            // edge detectors clear so a source already high re-latches
            readyPrev        <= 1'h0;
            swEnPrev         <= 1'h0;
            irqOut           <= 1'h0;
            masterIrq        <= 1'h0;
            regRdata         <= RESET_VALUE;
        end
        else
        begin
            if (wrEnable)
                interrupt_enable <= regWdata & IMPL_MASK; // [RULE12]
            if (wrControl)
                outputEnable <= regWdata[OUTEN_BIT];
            readyPrev <= deviceReady;
            swEnPrev  <= software_irq_trigger_enable;
            irqOut    <= next_irqOut;  // [RULE14]
            masterIrq <= irqLine;      // [RULE15]
            if (regRead)
                regRdata <= readMux;
        end
    end
endmodule : top_level_interrupt_aggregator
`default_nettype wire

// ---- sim/tlia_properties.sv ----
// Purpose: port checks for the interrupt aggregator
// Assumes: read data loads at the read edge
// Notes:   enable and control are shadowed from writes
`timescale 1ns/1ps
`default_nettype none
module tlia_properties
    import tlia_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        nrst,
    input wire logic [11:0] regAddr,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [31:0] regWdata,
    input wire logic [31:0] regRdata,
    input wire logic        ptp_unit_event,
    input wire logic        irqOut,
    input wire logic        masterIrq
);
    logic [31:0] enCopy;
    logic        outEn;
    wire logic   rdStat = regRead && regAddr == STATUS_OFFSET;
    wire logic   rdEn = regRead && regAddr == ENABLE_OFFSET;
    wire logic   rdCtl = regRead && regAddr == CONTROL_OFFSET;
    // shadows stand in for registers the ports cannot show
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            enCopy <= 32'h0;
            outEn <= 1'h0;
        end
        else if (regWrite && regAddr == ENABLE_OFFSET)
            enCopy <= regWdata & IMPL_MASK;
        else if (regWrite && regAddr == CONTROL_OFFSET)
            outEn <= regWdata[OUTEN_BIT];
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    a_reset_quiet: assert property (
        $rose(nrst) |-> regRdata == 32'h0 && !irqOut && !masterIrq)
        else $error("outputs not clear after reset");
    a_rdata_holds: assert property (!regRead |=> $stable(regRdata))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (
        regRead && !rdStat && !rdEn && !rdCtl |=> regRdata == 32'h0)
        else $error("unmapped read not zero");
    a_stat_reserved: assert property (
        rdStat |=> (regRdata & ~IMPL_MASK) == 32'h0)
        else $error("reserved status bit set");
    a_enable_read: assert property (
        rdEn |=> regRdata == $past(enCopy))
        else $error("enable read back wrong");
    a_none_enabled: assert property (
        enCopy == 32'h0 |=> !masterIrq)
        else $error("master set with nothing enabled");
    a_mirror_read: assert property (
        rdStat && $past(nrst) && $stable(ptp_unit_event)
        |=> regRdata[PTP_BIT] == $past(ptp_unit_event))
        else $error("time unit bit not mirrored");
    a_mirror_irq: assert property (
        ptp_unit_event && $past(ptp_unit_event) && enCopy[PTP_BIT]
        |=> masterIrq) else $error("enabled event not raised");
    a_irq_gating: assert property (
        $past(nrst) |-> irqOut == (masterIrq && $past(outEn)))
        else $error("request output not gated");
    c_ready_seen: cover property (rdStat ##1 regRdata[READY_BIT]);
    c_irq_out: cover property (irqOut);
    c_irq_held: cover property (masterIrq && !irqOut);
endmodule : tlia_properties
bind top_level_interrupt_aggregator tlia_properties u_props (
    .sys_clk(sys_clk), .nrst(nrst), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
    .regRdata(regRdata), .ptp_unit_event(ptp_unit_event),
    .irqOut(irqOut), .masterIrq(masterIrq));
`default_nettype wire

// ---- sim/testbench.sv ----
// Purpose: self-checking bench for the interrupt aggregator
// Assumes: one register access at a time
// Notes:   mirrors run as rows, latched flags by hand
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import tlia_pkg::*;
    typedef struct packed
    {logic [4:0] src; logic [31:0] en, stat; logic mst;} tlia_row_t;
    tlia_row_t rows [5] = '{'{5'h10, 32'h20000000, 32'h20000000, 1'h1},
        '{5'h08, 32'h20000000, 32'h10000000, 1'h0},
        '{5'h06, 32'h0C000000, 32'h0C000000, 1'h1},
        '{5'h01, 32'h00001000, 32'h00001000, 1'h1},
        '{5'h1F, 32'h00000000, 32'h3C001000, 1'h0}};
    logic        sys_clk, nrst, regWrite, regRead, deviceReady;
    logic        irqOut, masterIrq;
    logic [4:0]  src;
    logic [11:0] regAddr;
    logic [15:0] tCount;
    logic [31:0] regWdata, regRdata, v;
    int          n_fail = 0, checked = 0, cyc = 0;
    top_level_interrupt_aggregator dut (.sys_clk(sys_clk), .nrst(nrst),
        .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
        .regWdata(regWdata), .regRdata(regRdata),
        .deviceReady(deviceReady), .ptp_unit_event(src[4]),
        .fabricEvent(src[3]), .port_b_transceiver_event(src[2]),
        .port_a_transceiver_event(src[1]), .timer_count(tCount),
        .gpioEvent(src[0]), .irqOut(irqOut), .masterIrq(masterIrq));
    task test_done;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task wr_reg(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'h1;
        @(posedge sys_clk);
        regWrite <= 1'h0;
    endtask : wr_reg
    task rd_reg(input logic [11:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regRead <= 1'h1;
        @(posedge sys_clk);
        regRead <= 1'h0;
        #1 d = regRdata;
    endtask : rd_reg
    initial
    begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end
    // a hang anywhere ends here; the tests need some 90 cycles
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_fail++;
            test_done();
        end
    end
    initial
    begin
        {nrst, regWrite, regRead, deviceReady, src} = 9'h0;
        {regAddr, tCount, regWdata} = 60'h0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'h1;
        foreach (rows[i])
        begin
            @(posedge sys_clk);
            src <= rows[i].src;
            wr_reg(ENABLE_OFFSET, rows[i].en);
            repeat (2) @(posedge sys_clk);
            rd_reg(STATUS_OFFSET, v);
            chk(v, rows[i].stat);
            chk({31'h0, masterIrq}, {31'h0, rows[i].mst});
        end
        $display("mirror rows done");
        @(posedge sys_clk);
        {src, deviceReady} <= 6'h01;
        wr_reg(STATUS_OFFSET, 32'h3FFFFFFF);
        rd_reg(STATUS_OFFSET, v);
        chk(v, 32'h40000000);
        wr_reg(STATUS_OFFSET, 32'h40000000);
        rd_reg(STATUS_OFFSET, v);
        chk(v, 32'h0);
        $display("ready test done");
        wr_reg(ENABLE_OFFSET, 32'hFFFFFFFF);
        rd_reg(ENABLE_OFFSET, v);
        chk(v, IMPL_MASK);
        rd_reg(STATUS_OFFSET, v);
        chk(v, 32'h80000000);
        chk({31'h0, irqOut}, 32'h0);
        wr_reg(CONTROL_OFFSET, 32'h00000100);
        rd_reg(CONTROL_OFFSET, v);
        chk(v, 32'h00001100);
        chk({31'h0, irqOut}, 32'h1);
        wr_reg(STATUS_OFFSET, 32'h80000000);
        rd_reg(STATUS_OFFSET, v);
        chk(v, 32'h0);
        chk({31'h0, irqOut}, 32'h0);
        $display("software test done");
        for (int k = 0; k < 3; k++)
        begin
            @(posedge sys_clk);
            tCount <= 16'h0001 - 16'(k);
        end
        repeat (3) @(posedge sys_clk);
        rd_reg(STATUS_OFFSET, v);
        chk(v, 32'h00080000);
        chk({31'h0, masterIrq}, 32'h1);
        wr_reg(STATUS_OFFSET, 32'h00080000);
        wr_reg(12'h064, 32'hFFFFFFFF);
        rd_reg(12'h064, v);
        chk(v, 32'h0);
        rd_reg(STATUS_OFFSET, v);
        chk(v, 32'h0);
        $display("timer test done");
        // ready edge and its clear write land on one edge: set must win
        @(posedge sys_clk);
        deviceReady <= 1'h0;
        @(posedge sys_clk);
        {deviceReady, regWrite} <= 2'h3;
        {regAddr, regWdata} <= {STATUS_OFFSET, 32'h40000000};
        @(posedge sys_clk);
        regWrite <= 1'h0;
        rd_reg(STATUS_OFFSET, v);
        chk(v, 32'h40000000);
        $display("set versus clear test done");
        // mid-run reset with ready still high: bit 30 latches again
        @(posedge sys_clk);
        nrst <= 1'h0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'h1;
        rd_reg(STATUS_OFFSET, v);
        chk(v, 32'h40000000);
        rd_reg(ENABLE_OFFSET, v);
        chk(v, 32'h0);
        rd_reg(CONTROL_OFFSET, v);
        chk(v, 32'h0);
        chk({30'h0, irqOut, masterIrq}, 32'h0);
        $display("reset test done");
        test_done();
    end
endmodule : testbench
`default_nettype wire
